// ==== src/vpic_pkg.sv ====
// Package: register map, field positions and constants of the interrupt controller
package vpic_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_REQ      = 72;   // Implemented request numbers 0..71
  localparam int NUM_SLOT     = 80;   // Five banks of sixteen flag slots
  localparam int NUM_BANK     = 5;
  localparam int NUM_PRIO_REG = 18;
  localparam int NUM_EXT      = 5;
  localparam int NUM_TRAP     = 6;    // Status bits 1..6 of control one

  // ****************************************************************
  // Register addresses (word index on the plain port)
  // ****************************************************************
  localparam logic [5:0] ADDR_CTRL_ONE  = 6'h00;
  localparam logic [5:0] ADDR_CTRL_TWO  = 6'h01;
  localparam logic [5:0] ADDR_FLAG_BASE = 6'h02;
  localparam logic [5:0] ADDR_EN_BASE   = 6'h07;
  localparam logic [5:0] ADDR_PRIO_BASE = 6'h0c;
  localparam logic [5:0] ADDR_PEND_VEC  = 6'h1e;
  localparam logic [5:0] ADDR_STATUS    = 6'h1f;
  localparam logic [5:0] ADDR_CORE_CTRL = 6'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_NEST_DIS  = 15;
  localparam int POS_ALT_SEL   = 15;
  localparam int POS_LEVEL_LO  = 5;
  localparam int POS_LEVEL_TOP = 3;
  localparam int POS_PEND_LVL  = 8;

  // ****************************************************************
  // Vector map
  // ****************************************************************
  localparam logic [6:0]  VEC_OFFSET    = 7'h08;
  localparam logic [23:0] PRI_TRAP_BASE = 24'h000004;
  localparam logic [23:0] PRI_TRAP_LAST = 24'h000012;
  localparam logic [23:0] PRI_USER_BASE = 24'h000014;
  localparam logic [23:0] ALT_USER_BASE = 24'h000114;
  localparam logic [23:0] ALT_OFFSET    = 24'h000100;
  localparam logic [23:0] ALT_TABLE_END = 24'h0001fe;
  localparam logic [23:0] CODE_START    = 24'h000200;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [2:0]  RST_PRIO  = 3'h0;
  localparam logic [2:0]  RST_LEVEL = 3'h0;

  // Trap request priority: oscillator, address, stack, math, dma
  typedef enum logic [2:0] {
    VPIC_TRAP_NONE = 3'b000,
    VPIC_TRAP_OSC  = 3'b001,
    VPIC_TRAP_ADDR = 3'b010,
    VPIC_TRAP_STK  = 3'b011,
    VPIC_TRAP_MATH = 3'b100,
    VPIC_TRAP_DMA  = 3'b101
  } vpic_trap_t;

endpackage : vpic_pkg

// ==== src/vpic_ctrl.sv ====
// Module: vectored priority interrupt and trap controller
// Summary of operation
// - Request n is vector n plus 8
// - Eight trap vectors at 0x04 through 0x12
// - Alternate table is primary plus 0x100
// - Requests above 71 never assert
// - Bits allocated in ascending request order
// - Thirty-three controller registers provided
// - Flags set by source, cleared by zero
// - Disabled source never requests the CPU
// - Three-bit priority per user source
// - Pending vector and level latched
// - Three writable level bits at 7:5
// - Top level bit read-only to software
// - Top bit set blocks all user interrupts
// - Level code 111 blocks user interrupts
// - Nesting disable freezes level bit writes
// - Control one: nesting disable, trap flags
// - Control two: edge selects, table select
// - Equal priority: lower request number wins
// - Alternate select redirects every vector
// - Edge select one means falling edge
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module vpic_ctrl
  import vpic_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               clkEn,
  input  wire logic [5:0]         regAddr,
  input  wire logic [15:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [15:0]        regRdata,
  input  wire logic [NUM_REQ-1:0] srcEvent,
  input  wire logic [NUM_EXT-1:0] extPin,
  input  wire logic [NUM_TRAP-1:0] trapEvent,
  input  wire logic               levelTopSet,
  input  wire logic               levelTopClr,
  output logic                    irqReq,
  output logic      [6:0]         irqVector,
  output logic      [3:0]         irqLevel,
  output logic      [23:0]        vectorAddr,
  output logic                    trapReq,
  output logic      [23:0]        trapAddr
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [NUM_SLOT-1:0] flagBits;
  logic [NUM_SLOT-1:0] enBits;
  logic [2:0]          prioField [NUM_SLOT];
  logic [15:0]         ctrlOne;
  logic [15:0]         ctrlTwo;
  logic [2:0]          cpuLevelLo;
  logic                levelTop;
  logic [6:0]          pendVec;
  logic [3:0]          pendLvl;
  logic [15:0]         rdData;
  logic [NUM_EXT-1:0]  extS1, extS2, extS3;
  logic [NUM_EXT-1:0]  extLevel;

  // Valid slots: implemented and not reserved
  localparam logic [NUM_SLOT-1:0] SLOT_VALID = {
    8'h00, 8'hf6, 8'h21, 8'hff, 8'hdf, 8'hff, 8'hff, 8'hfb,
    8'h7f, 8'hff};

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic       ce      = clkEn;
  wire logic [5:0] flagIdx = regAddr - ADDR_FLAG_BASE;
  wire logic [5:0] enIdx   = regAddr - ADDR_EN_BASE;
  wire logic [5:0] prioIdx = regAddr - ADDR_PRIO_BASE;
  wire logic hitFlag = regAddr >= ADDR_FLAG_BASE && regAddr < ADDR_EN_BASE;
  wire logic hitEn   = regAddr >= ADDR_EN_BASE && regAddr < ADDR_PRIO_BASE;
  wire logic hitPrio = regAddr >= ADDR_PRIO_BASE && regAddr < ADDR_PEND_VEC;
  wire logic wrOne   = regWr && regAddr == ADDR_CTRL_ONE;
  wire logic wrTwo   = regWr && regAddr == ADDR_CTRL_TWO;
  wire logic wrStat  = regWr && regAddr == ADDR_STATUS;
  wire logic nestDis = ctrlOne[POS_NEST_DIS];
  wire logic altSel  = ctrlTwo[POS_ALT_SEL];
  wire logic [3:0] cpuLevel = {levelTop, cpuLevelLo};

  // ****************************************************************
  // External pin synchronisers and edge detection
  // ****************************************************************
  // Second and third stages agree: the pin has settled
  wire logic [NUM_EXT-1:0] extAgree = ~(extS2 ^ extS3);

  // Three-stage synchroniser plus the last settled pin level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extS1    <= '0;
      extS2    <= '0;
      extS3    <= '0;
      extLevel <= '0;
    end else if (ce) begin
      extS1    <= extPin;
      extS2    <= extS1;
      extS3    <= extS2;
      extLevel <= (extS3 & extAgree) | (extLevel & ~extAgree);
    end
  end

  // Falling edge when polarity bit set, rising otherwise; a glitch
  // that never settles in both stages is not counted
  wire logic [NUM_EXT-1:0] extEdge = extAgree & (
    (ctrlTwo[NUM_EXT-1:0] & extLevel & ~extS3) |
    (~ctrlTwo[NUM_EXT-1:0] & ~extLevel & extS3));

  // External request slot numbers
  localparam int EXT_SLOT [NUM_EXT] = '{0, 20, 29, 53, 54};

  // ****************************************************************
  // Per-slot flags, enables and priorities
  // ****************************************************************
  logic [NUM_SLOT-1:0] setEv;
  logic [NUM_SLOT-1:0] qual;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOT; gi++) begin : g_slot
      localparam int BK = gi / 16;
      localparam int BT = gi % 16;
      localparam int PR = gi / 4;
      localparam int PB = (gi % 4) * 4;
      logic extHit;
      always_comb begin
        extHit = 1'b0;
        for (int e = 0; e < NUM_EXT; e++)
          if (EXT_SLOT[e] == gi) extHit = extEdge[e];
      end
      if (gi < NUM_REQ) begin : g_src
        assign setEv[gi] = SLOT_VALID[gi] && (srcEvent[gi] || extHit);
      end else begin : g_none
        assign setEv[gi] = 1'b0;
      end
      // Set wins over a software write of zero
      always_ff @(posedge core_clk) begin
        if (srst) begin
          flagBits[gi]  <= 1'b0;
          enBits[gi]    <= 1'b0;
          prioField[gi] <= RST_PRIO;
        end else if (ce) begin
          if (setEv[gi])
            flagBits[gi] <= 1'b1;
          else if (regWr && hitFlag && flagIdx == 6'(BK))
            flagBits[gi] <= regWdata[BT] & SLOT_VALID[gi];
          if (regWr && hitEn && enIdx == 6'(BK))
            enBits[gi] <= regWdata[BT] & SLOT_VALID[gi];
          if (regWr && hitPrio && prioIdx == 6'(PR))
            prioField[gi] <= regWdata[PB +: 3];
        end
      end
      // Eligible: flagged, enabled, above CPU level
      assign qual[gi] = flagBits[gi] && enBits[gi] &&
                        {1'b0, prioField[gi]} > cpuLevel;
    end
  endgenerate

  // ****************************************************************
  // Arbitration: highest priority, lowest number on tie
  // ****************************************************************
  logic [6:0] winIdx;
  logic [2:0] winPrio;
  logic       winAny;
  always_comb begin
    winIdx  = 7'h00;
    winPrio = 3'h0;
    winAny  = 1'b0;
    for (int i = NUM_SLOT - 1; i >= 0; i--) begin
      if (qual[i] && (!winAny || prioField[i] >= winPrio)) begin
        winIdx  = 7'(i);
        winPrio = prioField[i];
        winAny  = 1'b1;
      end
    end
  end

  // Trap priority by natural order
  vpic_trap_t trapSel;
  always_comb begin
    trapSel = VPIC_TRAP_NONE;
    if (ctrlOne[5])      trapSel = VPIC_TRAP_DMA;
    if (ctrlOne[4])      trapSel = VPIC_TRAP_MATH;
    if (ctrlOne[6])      trapSel = VPIC_TRAP_MATH;
    if (ctrlOne[2])      trapSel = VPIC_TRAP_STK;
    if (ctrlOne[3])      trapSel = VPIC_TRAP_ADDR;
    if (ctrlOne[1])      trapSel = VPIC_TRAP_OSC;
  end

  // ****************************************************************
  // Control, status and pending registers
  // ****************************************************************
  // Trap status bits set by hardware, write to clear or set
  wire logic [15:0] trapSetMask = {9'h000, trapEvent, 1'b0};
  wire logic [15:0] oneWrMask   = 16'h807e;
  wire logic [15:0] twoWrMask   = 16'h801f;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrlOne    <= RST_WORD;
      ctrlTwo    <= RST_WORD;
      cpuLevelLo <= RST_LEVEL;
      levelTop   <= 1'b0;
      pendVec    <= 7'h00;
      pendLvl    <= 4'h0;
    end else if (ce) begin
      if (wrOne)
        ctrlOne <= (regWdata & oneWrMask) | trapSetMask;
      else
        ctrlOne <= ctrlOne | trapSetMask;
      if (wrTwo)
        ctrlTwo <= regWdata & twoWrMask;
      if (wrStat && !nestDis)
        cpuLevelLo <= regWdata[POS_LEVEL_LO +: 3];
      // Top bit driven only by core trap entry and exit
      if (levelTopSet)
        levelTop <= 1'b1;
      else if (levelTopClr)
        levelTop <= 1'b0;
      if (winAny) begin
        pendVec <= winIdx + VEC_OFFSET;
        pendLvl <= {1'b0, winPrio};
      end else begin
        pendVec <= 7'h00;
        pendLvl <= 4'h0;
      end
    end
  end

  // ****************************************************************
  // Vector address generation
  // ****************************************************************
  wire logic [23:0] userAddr = PRI_USER_BASE + 24'({winIdx, 1'b0});
  wire logic [23:0] trapPri  = PRI_TRAP_BASE +
                               24'({trapSel, 1'b0});
  wire logic [23:0] altAdd   = altSel ? ALT_OFFSET : 24'h000000;

  always_comb begin
    irqReq     = winAny;
    irqVector  = pendVec;
    irqLevel   = pendLvl;
    vectorAddr = userAddr + altAdd;
    trapReq    = trapSel != VPIC_TRAP_NONE;
    trapAddr   = trapReq ? trapPri + altAdd : 24'h000000;
  end

  // ****************************************************************
  // Read mux, one cycle later
  // ****************************************************************
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    if (regAddr == ADDR_CTRL_ONE)  rdMux = ctrlOne;
    if (regAddr == ADDR_CTRL_TWO)  rdMux = ctrlTwo;
    if (hitFlag)
      rdMux = 16'(flagBits >> {flagIdx[2:0], 4'h0});
    if (hitEn)
      rdMux = 16'(enBits >> {enIdx[2:0], 4'h0});
    if (hitPrio)
      for (int k = 0; k < 4; k++)
        if (prioIdx * 4 + k < NUM_SLOT)
          rdMux[k*4 +: 3] = prioField[7'(prioIdx * 4 + k)];
    if (regAddr == ADDR_PEND_VEC)
      rdMux = {4'h0, pendLvl, 1'b0, pendVec};
    if (regAddr == ADDR_STATUS)
      rdMux[POS_LEVEL_LO +: 3] = cpuLevelLo;
    if (regAddr == ADDR_CORE_CTRL)
      rdMux[POS_LEVEL_TOP] = levelTop;
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      rdData <= RST_WORD;
    else if (ce && regRd)
      rdData <= rdMux;
  end
  assign regRdata = rdData;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_disabled_no_irq: assert property (
    irqReq |-> enBits[winIdx] && flagBits[winIdx])
    else $error("irq from disabled or unflagged source");
  a_level_above_cpu: assert property (
    irqReq |-> {1'b0, winPrio} > cpuLevel)
    else $error("irq not above cpu level");
  a_top_blocks_user: assert property (
    levelTop |-> !irqReq)
    else $error("user irq while top bit set");
  a_code_seven_block: assert property (
    cpuLevelLo == 3'h7 |-> !irqReq)
    else $error("user irq at level seven");
  a_vector_plus_eight: assert property (
    ce && winAny |=> pendVec == $past(winIdx) + 7'h08)
    else $error("pending vector not request plus eight");
  a_nest_freeze: assert property (
    ce && wrStat && nestDis |=> $stable(cpuLevelLo))
    else $error("level changed under nesting disable");
  a_high_slot_idle: assert property (
    flagBits[NUM_SLOT-1:NUM_REQ] == '0)
    else $error("unimplemented flag set");
  a_flag_set_wins: assert property (
    ce && setEv[0] |=> flagBits[0])
    else $error("flag set lost");
  a_alt_offset: assert property (
    altSel |-> vectorAddr == userAddr + ALT_OFFSET)
    else $error("alternate table not applied");
  a_read_next: assert property (
    ce && regRd && regAddr == ADDR_CTRL_TWO |=> regRdata == $past(ctrlTwo))
    else $error("read data wrong");

  // Pending level, trap table and top bit checks
  a_pending_level: assert property (
    ce && winAny |=> pendLvl == {1'b0, $past(winPrio)})
    else $error("pending level not winner priority");
  a_trap_in_table: assert property (
    trapReq && !altSel |-> trapAddr >= PRI_TRAP_BASE + 24'h000002 &&
    trapAddr <= PRI_TRAP_LAST - 24'h000004)
    else $error("trap address outside trap vectors");
  a_top_read_only: assert property (
    ce && regWr && regAddr == ADDR_CORE_CTRL && !levelTopSet &&
    !levelTopClr |=> $stable(levelTop))
    else $error("software changed top level bit");
  // One settled pin change gives a single set pulse
  a_ext_one_pulse: assert property (
    ce && extEdge[0] |=> !extEdge[0])
    else $error("external edge longer than one cycle");

  c_irq_raised:  cover property (irqReq);
  c_trap_raised: cover property (trapReq);
  c_alt_irq:     cover property (irqReq && altSel);
  c_tie_break:   cover property (qual[1] && qual[3] && winIdx == 7'h01);
  c_ext_edge:    cover property (extEdge != '0);

endmodule : vpic_ctrl

`default_nettype wire

// ==== test/vpic_cpu_model.sv ====
// Partner model: CPU core side of the vectored request interface
`timescale 1ns/10ps
`default_nettype none

module vpic_cpu_model (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic trapReq,
  input  wire logic trapReturn,
  output logic      levelTopSet,
  output logic      levelTopClr
);
  logic trapSeen;

  // Trap entry raises the top level bit once, return lowers it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trapSeen    <= 1'b0;
      levelTopSet <= 1'b0;
      levelTopClr <= 1'b0;
    end else begin
      trapSeen    <= trapReq;
      levelTopSet <= trapReq & ~trapSeen;
      levelTopClr <= trapReturn;
    end
  end
endmodule : vpic_cpu_model

`default_nettype wire

// ==== test/tb_vectored_priority_interrupt_ctrl.sv ====
// Testbench: register, vector and level checks of the controller
`timescale 1ns/10ps
`default_nettype none

module tb_vectored_priority_interrupt_ctrl;
  import vpic_pkg::*;
  logic                core_clk, srst, clkEn, regWr, regRd;
  logic [5:0]          regAddr;
  logic [15:0]         regWdata, regRdata;
  logic [NUM_REQ-1:0]  srcEvent;
  logic [NUM_EXT-1:0]  extPin;
  logic [NUM_TRAP-1:0] trapEvent;
  logic                levelTopSet, levelTopClr, trapReturn;
  logic                irqReq, trapReq;
  logic [6:0]          irqVector;
  logic [3:0]          irqLevel;
  logic [23:0]         vectorAddr, trapAddr;
  logic [23:0]         trapExp [6];
  int                  miscompares, n_compared, n;

  vpic_ctrl i_dut (.core_clk(core_clk), .srst(srst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .srcEvent(srcEvent),
    .extPin(extPin), .trapEvent(trapEvent), .levelTopSet(levelTopSet),
    .levelTopClr(levelTopClr), .irqReq(irqReq), .irqVector(irqVector),
    .irqLevel(irqLevel), .vectorAddr(vectorAddr), .trapReq(trapReq),
    .trapAddr(trapAddr));

  vpic_cpu_model i_cpu (.core_clk(core_clk), .srst(srst),
    .trapReq(trapReq), .trapReturn(trapReturn),
    .levelTopSet(levelTopSet), .levelTopClr(levelTopClr));

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // Read one word and compare it in the cycle after the strobe
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {8'h00, regRdata}, {8'h00, exp});
  endtask : rdc

  task automatic ev(input logic [NUM_REQ-1:0] v);
    @(posedge core_clk);
    srcEvent <= v;
    @(posedge core_clk);
    srcEvent <= {NUM_REQ{1'b0}};
    #1;
  endtask : ev

  task automatic trap(input logic [NUM_TRAP-1:0] v);
    @(posedge core_clk);
    trapEvent <= v;
    @(posedge core_clk);
    trapEvent <= {NUM_TRAP{1'b0}};
    #1;
  endtask : trap

  // Bounded wait for a request to the core
  task automatic wait_irq;
    int i;
    for (i = 0; i < 20 && irqReq !== 1'b1; i++)
      @(posedge core_clk);
    #1;
    check("irqReq wait", {23'h0, irqReq}, 24'h1);
  endtask : wait_irq

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  initial begin
    srst = 1'b1; clkEn = 1'b1; regWr = 1'b0; regRd = 1'b0;
    regAddr = 6'h00; regWdata = 16'h0000; srcEvent = {NUM_REQ{1'b0}};
    extPin = 5'h00; trapEvent = 6'h00; trapReturn = 1'b0;
    miscompares = 0; n_compared = 0;
    trapExp = '{24'h06, 24'h0a, 24'h08, 24'h0c, 24'h0e, 24'h0c};
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    // Whole map reads zero after reset, unmapped writes ignored
    wr(6'h21, 16'hffff);
    for (n = 0; n < 64; n++) rdc(6'(n), 16'h0000);
    // Vector numbers and bank allocation for spread requests
    foreach (trapExp[k]) begin
      n = (k == 0) ? 0 : (k == 1) ? 17 : (k == 2) ? 33 : 71;
      wr(6'(ADDR_EN_BASE + n / 16), 16'(1 << (n % 16)));
      wr(6'(ADDR_PRIO_BASE + n / 4), 16'(2 << (4 * (n % 4))));
      check("idle irq", {23'h0, irqReq}, 24'h0);
      ev(NUM_REQ'(1) << n);
      rdc(6'(ADDR_FLAG_BASE + n / 16), 16'(1 << (n % 16)));
      check("vec addr", vectorAddr, PRI_USER_BASE + 24'(2 * n));
      check("vec num", {17'h0, irqVector}, 24'(n + 8));
      check("level", {20'h0, irqLevel}, 24'h2);
      rdc(ADDR_PEND_VEC, 16'h0200 | 16'(n + 8));
      wr(6'(ADDR_FLAG_BASE + n / 16), 16'h0000);
      check("cleared irq", {23'h0, irqReq}, 24'h0);
      wr(6'(ADDR_EN_BASE + n / 16), 16'h0000);
      wr(6'(ADDR_PRIO_BASE + n / 4), 16'h0000);
    end
    // Flag without enable, then tie at equal priority
    wr(ADDR_PRIO_BASE, 16'h5050);
    ev(72'h00a);
    check("disabled", {23'h0, irqReq}, 24'h0);
    wr(ADDR_EN_BASE, 16'h000a);
    check("tie", vectorAddr, 24'h000016);
    wr(ADDR_PRIO_BASE, 16'h7050);
    rdc(ADDR_PRIO_BASE, 16'h7050);
    check("high wins", vectorAddr, 24'h00001a);
    // Level compare is strict, code 111 blocks all
    wr(ADDR_STATUS, 16'h00c0);
    check("above lvl", {23'h0, irqReq}, 24'h1);
    wr(ADDR_PRIO_BASE, 16'h6000);
    check("equal lvl", {23'h0, irqReq}, 24'h0);
    wr(ADDR_PRIO_BASE, 16'h7050);
    wr(ADDR_STATUS, 16'h00e0);
    rdc(ADDR_STATUS, 16'h00e0);
    check("lvl 7", {23'h0, irqReq}, 24'h0);
    // Nesting disable freezes the level bits
    wr(ADDR_CTRL_ONE, 16'h8000);
    wr(ADDR_STATUS, 16'h0000);
    rdc(ADDR_STATUS, 16'h00e0);
    rdc(ADDR_CTRL_ONE, 16'h8000);
    wr(ADDR_CTRL_ONE, 16'h0000);
    wr(ADDR_STATUS, 16'h0000);
    // Alternate table for interrupts and traps
    wr(ADDR_CTRL_TWO, 16'h8000);
    rdc(ADDR_CTRL_TWO, 16'h8000);
    check("alt vec", vectorAddr, 24'h00011a);
    trap(6'h01);
    check("alt trap", trapAddr, 24'h000106);
    wr(ADDR_CTRL_TWO, 16'h0000);
    // Top level bit set by the core blocks users, software cannot clear
    rdc(ADDR_CORE_CTRL, 16'h0008);
    check("top blocks", {23'h0, irqReq}, 24'h0);
    wr(ADDR_CORE_CTRL, 16'h0000);
    rdc(ADDR_CORE_CTRL, 16'h0008);
    wr(ADDR_CTRL_ONE, 16'h0000);
    // Each trap source sets its flag and vector
    foreach (trapExp[k]) begin
      trap(6'(1 << k));
      rdc(ADDR_CTRL_ONE, 16'(2 << k));
      check("trap addr", trapAddr, trapExp[k]);
      wr(ADDR_CTRL_ONE, 16'h0000);
    end
    @(posedge core_clk);
    trapReturn <= 1'b1;
    @(posedge core_clk);
    trapReturn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("user back", {23'h0, irqReq}, 24'h1);
    wr(ADDR_FLAG_BASE, 16'h0000);
    // Reserved slots never set or enable
    wr(ADDR_EN_BASE, 16'hffff);
    rdc(ADDR_EN_BASE, 16'h7fff);
    wr(6'(ADDR_EN_BASE + 4), 16'hffff);
    rdc(6'(ADDR_EN_BASE + 4), 16'h00f6);
    ev(72'h8000);
    rdc(ADDR_FLAG_BASE, 16'h0000);
    // External request zero, rising then falling select
    wr(ADDR_PRIO_BASE, 16'h0001);
    @(posedge core_clk);
    extPin <= 5'h01;
    wait_irq();
    check("ext vec", vectorAddr, 24'h000014);
    wr(ADDR_FLAG_BASE, 16'h0000);
    wr(ADDR_CTRL_TWO, 16'h0001);
    @(posedge core_clk);
    extPin <= 5'h00;
    wait_irq();
    wr(ADDR_FLAG_BASE, 16'h0000);
    @(posedge core_clk);
    extPin <= 5'h01;
    repeat (8) @(posedge core_clk);
    #1;
    check("no rise", {23'h0, irqReq}, 24'h0);
    conclude();
  end
endmodule : tb_vectored_priority_interrupt_ctrl

`default_nettype wire
